// file: hdl/bb_dvs_select.sv
// Purpose: voltage scaling select register bank for the buck-boost output
// Assumes: register port decoded from the serial configuration port
// Notes:   target follows pins two clocks later
`timescale 1ns/1ps
`default_nettype none
module bb_dvs_select
	import bb_dvs_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       RESET_N,
	input  wire reg_req_t   REG_REQ,
	output logic      [7:0] REG_RDATA,
	input  wire logic [7:0] MULTI_PURPOSE_PIN,
	output target_t         TARGET
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// release is synchronised so every flop leaves reset on the same edge;
	// entry stays immediate so junk on the pins never reaches the target
	logic [1:0] rst_sync;
	logic [1:0] next_rst_sync;
	logic       rst_n;

	always_comb begin
		next_rst_sync = {rst_sync[0], 1'b1};
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= next_rst_sync;
		end
	end
	assign rst_n = rst_sync[1];

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [4:0] scaling_pin_pair_select;
	logic [4:0] next_scaling_pin_pair_select;
	logic [5:0] alt_voltage_code [ALT_COUNT];
	logic [5:0] next_alt_voltage_code [ALT_COUNT];
	logic [7:0] next_rdata;

	function automatic logic [7:0] pad_code(input logic [5:0] c);
		return {2'b00, c};
	endfunction

	always_comb begin
		next_scaling_pin_pair_select = scaling_pin_pair_select;
		for (int i = 0; i < ALT_COUNT; i++) begin
			next_alt_voltage_code[i] = alt_voltage_code[i];
		end
		if (REG_REQ.wr) begin
			if (REG_REQ.addr == OFS_PIN_PAIR_SELECT) begin
				next_scaling_pin_pair_select = REG_REQ.wdata[4:0];
			end
			// codes stored as written; range is the writer's duty
			for (int i = 0; i < ALT_COUNT; i++) begin
				if (REG_REQ.addr == OFS_ALT_VOLTAGE_0 + 8'(i)) begin
					next_alt_voltage_code[i] = REG_REQ.wdata[5:0];
				end
			end
		end
	end

	always_comb begin
		next_rdata = REG_RDATA;
		if (REG_REQ.rd) begin
			unique case (REG_REQ.addr)
				OFS_PIN_PAIR_SELECT: next_rdata = {3'b000, scaling_pin_pair_select};
				OFS_ALT_VOLTAGE_0:   next_rdata = pad_code(alt_voltage_code[0]);
				OFS_ALT_VOLTAGE_1:   next_rdata = pad_code(alt_voltage_code[1]);
				OFS_ALT_VOLTAGE_2:   next_rdata = pad_code(alt_voltage_code[2]);
				OFS_ALT_VOLTAGE_3:   next_rdata = pad_code(alt_voltage_code[3]);
				OFS_READBACK:        next_rdata = pad_code(TARGET.code);
				default:             next_rdata = RST_RDATA;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			scaling_pin_pair_select <= RST_PIN_PAIR;
			for (int i = 0; i < ALT_COUNT; i++) begin
				alt_voltage_code[i] <= RST_ALT_VOLTAGE;
			end
			REG_RDATA <= RST_RDATA;
		end else begin
			scaling_pin_pair_select <= next_scaling_pin_pair_select;
			for (int i = 0; i < ALT_COUNT; i++) begin
				alt_voltage_code[i] <= next_alt_voltage_code[i];
			end
			REG_RDATA <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// pin pair selection
	// ----------------------------------------------------------------
	logic [1:0] pair_state;
	logic       pair_valid;
	target_t    next_target;

	pin_pair_select u_pair (
		.clk        (SYS_CLK),
		.rst_n      (rst_n),
		.cfg        (scaling_pin_pair_select),
		.pins       (MULTI_PURPOSE_PIN),
		.pair_state (pair_state),
		.pair_valid (pair_valid)
	);

	always_comb begin
		// disabled shows code zero so the regulator keeps its normal setting
		next_target.active = pair_valid;
		next_target.code   = pair_valid ? alt_voltage_code[pair_state] : RST_SELECTED;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			TARGET <= '{active: 1'b0, code: RST_SELECTED};
		end else begin
			TARGET <= next_target;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_cfg_zero_held;
		scaling_pin_pair_select == CFG_DISABLED [*2];
	endsequence

	a_disabled_ignores: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		s_cfg_zero_held |=> !TARGET.active && TARGET.code == RST_SELECTED)
		else $error("scaling active while disabled");
	a_state01_alt1: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		pair_valid && pair_state == 2'b01 |=> TARGET.code == $past(alt_voltage_code[1]))
		else $error("state 01 did not apply setting 1");
	a_state_others: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		pair_valid && pair_state != 2'b01 |=>
		TARGET.code == $past(alt_voltage_code[pair_state]))
		else $error("pin state selected wrong setting");
	// end to end through both registers; a write inside the window could move
	// the setting under the check, so only write-free windows are judged
	a_pin_follow: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(scaling_pin_pair_select == 5'h01 && !REG_REQ.wr) [*3] |->
		TARGET.active &&
		TARGET.code == $past(alt_voltage_code[{MULTI_PURPOSE_PIN[0], MULTI_PURPOSE_PIN[1]}], 2))
		else $error("target did not follow pins");
	// write, one idle clock, then read back the same setting
	sequence s_alt2_write;
		REG_REQ.wr && REG_REQ.addr == OFS_ALT_VOLTAGE_2;
	endsequence

	sequence s_alt2_read;
		REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == OFS_ALT_VOLTAGE_2;
	endsequence

	a_alt_write_read: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		s_alt2_write ##1 !REG_REQ.wr ##1 s_alt2_read |=>
		REG_RDATA == {2'b00, $past(REG_REQ.wdata[5:0], 3)})
		else $error("alternate setting lost");
	a_readback_code: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.rd && REG_REQ.addr == OFS_READBACK |=> REG_RDATA == {2'b00, $past(TARGET.code)})
		else $error("readback mismatch");
	a_code_width: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.rd && REG_REQ.addr >= OFS_ALT_VOLTAGE_0 && REG_REQ.addr <= OFS_READBACK |=>
		REG_RDATA[7:6] == 2'b00)
		else $error("reserved bits set");
	a_select_range: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		pair_valid |-> $past(scaling_pin_pair_select) != CFG_DISABLED &&
		$past(scaling_pin_pair_select) <= CFG_LAST_PAIR)
		else $error("pair taken from a code without a pair");
	a_inactive_zero: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!TARGET.active |-> TARGET.code == RST_SELECTED)
		else $error("inactive target carries a code");

	// ----------------------------------------------------------------
	// register bank checks
	// ----------------------------------------------------------------
	// read data is a flop, so every read answers exactly one clock later
	a_cfg_readback: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.rd && REG_REQ.addr == OFS_PIN_PAIR_SELECT |=>
		REG_RDATA == {3'b000, $past(scaling_pin_pair_select)})
		else $error("pair select readback mismatch");
	a_unmapped_zero: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.rd && (REG_REQ.addr < OFS_PIN_PAIR_SELECT || REG_REQ.addr > OFS_READBACK) |=>
		REG_RDATA == RST_RDATA)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!REG_REQ.rd |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	a_alt_write_lands: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.wr && REG_REQ.addr == OFS_ALT_VOLTAGE_3 |=>
		alt_voltage_code[3] == $past(REG_REQ.wdata[5:0]))
		else $error("write to setting 3 did not land");
	a_alt_independent: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.wr && REG_REQ.addr == OFS_ALT_VOLTAGE_0 |=>
		$stable(alt_voltage_code[1]) && $stable(alt_voltage_code[2]) && $stable(alt_voltage_code[3]))
		else $error("write to setting 0 disturbed another setting");
	// the readback sits in the bank's address range but must never store
	a_readback_read_only: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		REG_REQ.wr && REG_REQ.addr == OFS_READBACK |=> $stable(scaling_pin_pair_select) &&
		$stable(alt_voltage_code[0]) && $stable(alt_voltage_code[1]) &&
		$stable(alt_voltage_code[2]) && $stable(alt_voltage_code[3]))
		else $error("write to readback changed a setting");
	a_bank_hold: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!REG_REQ.wr |=> $stable(scaling_pin_pair_select) && $stable(alt_voltage_code[0]) &&
		$stable(alt_voltage_code[1]) && $stable(alt_voltage_code[2]) && $stable(alt_voltage_code[3]))
		else $error("setting changed without a write");
endmodule
`default_nettype wire

// file: hdl/bb_dvs_pkg.sv
// Purpose: shared constants and types for buck-boost voltage scaling select
// Assumes: 8-bit register port, 6-bit voltage codes
// Notes:   reset values are plain defaults
package bb_dvs_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PIN_PAIR_SELECT = 8'h46;
	localparam logic [7:0] OFS_ALT_VOLTAGE_0   = 8'h47;
	localparam logic [7:0] OFS_ALT_VOLTAGE_1   = 8'h48;
	localparam logic [7:0] OFS_ALT_VOLTAGE_2   = 8'h49;
	localparam logic [7:0] OFS_ALT_VOLTAGE_3   = 8'h4a;
	localparam logic [7:0] OFS_READBACK        = 8'h4b;
	// ----------------------------------------------------------------
	// fields and codes
	// ----------------------------------------------------------------
	localparam int         CFG_W            = 5;
	localparam int         CODE_W           = 6;
	localparam int         PIN_COUNT        = 8;
	localparam int         ALT_COUNT        = 4;
	localparam logic [4:0] CFG_DISABLED     = 5'h00;
	localparam logic [4:0] CFG_RESERVED     = 5'h1d;
	localparam logic [4:0] CFG_LAST_PAIR    = 5'h1c;
	localparam logic [5:0] CODE_MAX_VALID   = 6'h3c;
	localparam logic [5:0] CODE_MIN_SAFE    = 6'h02;
	localparam int         CODE_BASE_MV     = 2500;
	localparam int         CODE_STEP_MV     = 50;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] RST_PIN_PAIR     = 5'h00;
	localparam logic [5:0] RST_ALT_VOLTAGE  = 6'h00;
	localparam logic [5:0] RST_SELECTED     = 6'h00;
	localparam logic [7:0] RST_RDATA        = 8'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       active;
		logic [5:0] code;
	} target_t;
endpackage

// file: hdl/pin_pair_select.sv
// Purpose: decode pin pair select code and register the pair state
// Assumes: pins synchronous to clk
// Notes:   first pin of the pair is the high bit of the state
`timescale 1ns/1ps
`default_nettype none
module pin_pair_select
	import bb_dvs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [4:0] cfg,
	input  wire logic [7:0] pins,
	output logic      [1:0] pair_state,
	output logic            pair_valid
);
	logic [1:0] next_pair_state;
	logic       next_pair_valid;

	// ----------------------------------------------------------------
	// code to pin pair, pairs counted in ascending order
	// ----------------------------------------------------------------
	function automatic logic [6:0] decode_pair(input logic [4:0] code);
		logic [6:0] res;
		logic [4:0] idx;
		res = 7'h00;
		idx = 5'h01;
		for (int a = 0; a < PIN_COUNT - 1; a++) begin
			for (int b = a + 1; b < PIN_COUNT; b++) begin
				if (idx == code) begin
					res = {1'b1, a[2:0], b[2:0]};
				end
				idx = idx + 5'h01;
			end
		end
		return res;
	endfunction

	always_comb begin
		logic [6:0] d;
		d = decode_pair(cfg);
		// reserved and unused codes fall through as no pair
		next_pair_valid = d[6] && (cfg != CFG_DISABLED) && (cfg != CFG_RESERVED);
		next_pair_state = next_pair_valid ? {pins[d[5:3]], pins[d[2:0]]} : 2'h0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pair_state <= 2'h0;
			pair_valid <= 1'b0;
		end else begin
			pair_state <= next_pair_state;
			pair_valid <= next_pair_valid;
		end
	end

	a_reserved_code: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg == CFG_RESERVED || cfg > CFG_LAST_PAIR) |=> !pair_valid)
		else $error("reserved code selected a pin pair");
	a_pair_zero_pins: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg == 5'h01) |=> pair_valid && pair_state == {$past(pins[0]), $past(pins[1])})
		else $error("pair 0/1 state wrong");
endmodule
`default_nettype wire

// file: testbench/mpc_host.sv
// Purpose: host model driving the multipurpose control pins
// Assumes: pins change on the falling clock edge, synchronous to the device
// Notes:   unselected pins carry a moving pattern so a wrong pair decode shows
`timescale 1ns/1ps
`default_nettype none
module mpc_host (
	input  wire logic       clk,
	input  wire logic [2:0] pin_a,
	input  wire logic [2:0] pin_b,
	input  wire logic [1:0] state,
	output logic      [7:0] pins
);
	logic [7:0] noise;
	logic [7:0] level;

	initial begin
		noise = 8'h5a;
		pins  = 8'h00;
	end

	// pin a is the high bit of the pair state
	always @(negedge clk) begin
		noise = {noise[6:0], noise[7] ^ noise[5]};
		level = noise;
		level[pin_a] = state[1];
		level[pin_b] = state[0];
		pins <= level;
	end
endmodule
`default_nettype wire

// file: testbench/tb_bb_dvs_select.sv
// Purpose: self-checking bench for the buck-boost scaling select bank
// Assumes: inputs driven on the falling edge, target settles two clocks after pins
// Notes:   config codes 1..28 walk the pin pairs in ascending order
`timescale 1ns/1ps
`default_nettype none
module tb_bb_dvs_select;
	import bb_dvs_pkg::*;
	logic       clk;
	logic       rst_n;
	reg_req_t   req;
	logic [7:0] rdata;
	logic [7:0] pins;
	target_t    target;
	logic [2:0] pa;
	logic [2:0] pb;
	logic [1:0] st;
	logic [5:0] alt [4];
	logic [4:0] off_codes [4];
	int         fail_count;
	int         n_compared;

	bb_dvs_select i_dut (.SYS_CLK(clk), .RESET_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
		.MULTI_PURPOSE_PIN(pins), .TARGET(target));
	mpc_host i_host (.clk(clk), .pin_a(pa), .pin_b(pb), .state(st), .pins(pins));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '0;
		@(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req = '0;
		chk("read data", rdata, exp);
		@(negedge clk);
	endtask

	function automatic void pair_of(input int c, output logic [2:0] a, output logic [2:0] b);
		int k;
		k = 0;
		a = 3'h0;
		b = 3'h1;
		for (int i = 0; i < 7; i++) begin
			for (int j = i + 1; j < 8; j++) begin
				k++;
				if (k == c) begin
					a = i[2:0];
					b = j[2:0];
				end
			end
		end
	endfunction

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		req = '0;
		pa = 3'h0;
		pb = 3'h1;
		st = 2'h0;
		fail_count = 0;
		n_compared = 0;
		off_codes = '{CFG_DISABLED, CFG_RESERVED, 5'h1e, 5'h1f};
		// software keeps codes within 2..60
		alt = '{6'h02, 6'h14, 6'h28, 6'h3c};
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int a = 'h46; a <= 'h4b; a++) rd(a[7:0], 8'h00);
		rd(8'h50, 8'h00);
		$display("test reset values done");
		wr(OFS_ALT_VOLTAGE_2, 8'h2a);
		rd(OFS_ALT_VOLTAGE_2, 8'h2a);
		for (int i = 0; i < 4; i++) wr(OFS_ALT_VOLTAGE_0 + i[7:0], {2'b00, alt[i]});
		wr(8'h50, 8'hff);
		for (int i = 0; i < 4; i++) rd(OFS_ALT_VOLTAGE_0 + i[7:0], {2'b00, alt[i]});
		rd(8'h50, 8'h00);
		wr(OFS_READBACK, 8'h3f);
		rd(OFS_READBACK, 8'h00);
		$display("test alternate registers done");
		for (int c = 1; c <= 28; c++) begin
			pair_of(c, pa, pb);
			wr(OFS_PIN_PAIR_SELECT, c[7:0]);
			for (int s = 0; s < 4; s++) begin
				st = s[1:0];
				repeat (3) @(negedge clk);
				chk("target", {1'b0, target}, {2'b01, alt[s]});
			end
			rd(OFS_READBACK, {2'b00, alt[3]});
		end
		$display("test pin pair selection done");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_PIN_PAIR_SELECT, {3'b000, off_codes[i]});
			for (int s = 0; s < 4; s++) begin
				st = s[1:0];
				repeat (3) @(negedge clk);
				chk("target", {1'b0, target}, 8'h00);
			end
			rd(OFS_READBACK, 8'h00);
			rd(OFS_PIN_PAIR_SELECT, {3'b000, off_codes[i]});
		end
		$display("test disabled codes done");
		final_report();
	end

	// the whole sequence needs about 570 cycles
	initial begin
		#100000;
		fail_count++;
		$display("watchdog expired");
		final_report();
	end
endmodule
`default_nettype wire
